//--- scwr_pkg.sv
package scwr_pkg;

    // ------------------------------------------------------------------
    // Register offsets and bus widths
    // ------------------------------------------------------------------
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 16;
    localparam logic [7:0] OFF_REFRESH_BASE = 8'hE0;
    localparam logic [7:0] OFF_REFRESH_INTERVAL = 8'hE2;
    localparam logic [7:0] OFF_REFRESH_ENABLE = 8'hE4;
    localparam logic [7:0] OFF_WATCHDOG = 8'hE6;
    localparam logic [7:0] OFF_SYSTEM_CFG = 8'hF0;
    localparam logic [7:0] OFF_AUX_CFG = 8'hF2;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] AUX_RESET = 16'h0000;
    localparam logic [15:0] SYS_RESET = 16'h0000;
    localparam logic [15:0] WDT_RESET = 16'hC080;
    localparam logic [15:0] AUX_WRITE_MASK = 16'h007F;
    localparam logic [15:0] SYS_WRITE_MASK = 16'hFF07;
    localparam logic [15:0] WDT_WRITE_MASK = 16'hF0FF;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int AUX_PORT1_RX_BIT = 6;
    localparam int AUX_PORT1_TX_BIT = 5;
    localparam int AUX_PORT0_RX_BIT = 4;
    localparam int AUX_PORT0_TX_BIT = 3;
    localparam int AUX_LOW_NARROW_BIT = 2;
    localparam int AUX_MID_NARROW_BIT = 1;
    localparam int AUX_IO_NARROW_BIT = 0;
    localparam int SYS_POWER_SAVE_BIT = 15;
    localparam int SYS_MID_WHOLE_BIT = 14;
    localparam int SYS_STROBE_MODE_BIT = 13;
    localparam int SYS_DEMOD_BIT = 12;
    localparam int SYS_CLKB_FREQ_BIT = 11;
    localparam int SYS_CLKB_LOW_BIT = 10;
    localparam int SYS_CLKA_FREQ_BIT = 9;
    localparam int SYS_CLKA_LOW_BIT = 8;
    localparam int SYS_DIV_MSB = 2;
    localparam int SYS_DIV_LSB = 0;
    localparam int WDT_ON_BIT = 15;
    localparam int WDT_RESET_SEL_BIT = 14;
    localparam int WDT_TIMEOUT_BIT = 13;
    localparam int WDT_NMI_BIT = 12;
    localparam int WDT_COUNT_MSB = 7;
    localparam int WDT_COUNT_LSB = 0;
    localparam int REFRESH_ON_BIT = 15;
    localparam int REFRESH_BASE_LSB = 9;

    // ------------------------------------------------------------------
    // Counter widths and watchdog exponents
    // ------------------------------------------------------------------
    localparam int DIV_W = 7;
    localparam int REFRESH_W = 9;
    localparam int REFRESH_BASE_W = 7;
    localparam int REFRESH_ROW_W = 13;
    localparam int WDT_TIMER_W = 27;
    localparam int WDT_EXP_BIT0 = 10;
    localparam int WDT_EXP_OFFSET = 19;

endpackage

//--- scwr_regs.sv
`timescale 1ns/100ps
module scwr_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [scwr_pkg::REG_ADDR_W-1:0] regOffset,
    input wire logic [scwr_pkg::REG_DATA_W-1:0] regWriteData,
    output logic [scwr_pkg::REG_DATA_W-1:0] regReadData,
    input wire logic hwInterrupt,
    input wire logic peripheralIsMemory,
    output logic port1_rx_flow_select,
    output logic port1_tx_flow_select,
    output logic port0_rx_flow_select,
    output logic port0_tx_flow_select,
    output logic low_region_narrow,
    output logic mid_region_narrow,
    output logic periphRegionNarrow,
    output logic io_space_narrow,
    output logic power_save_on,
    output logic internalClockEnable,
    output logic mid_select_whole_range,
    output logic strobe_mode_select,
    output logic demodulator_on,
    output logic clockOutA,
    output logic clockOutB,
    output logic watchdogNmi,
    output logic watchdogReset,
    output logic middleSelect3IsRefresh,
    output logic refreshRequest,
    output logic [19:0] refreshAddress
);
    import scwr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] auxCfg;
        logic [15:0] sysCfg;
        logic [15:0] wdtCtl;
        logic refreshOn;
        logic [REFRESH_W-1:0] refreshCount;
        logic [REFRESH_W-1:0] refreshInterval;
        logic [REFRESH_BASE_W-1:0] refreshBase;
        logic [REFRESH_ROW_W-1:0] refreshRow;
        logic [DIV_W-1:0] divCount;
        logic intClkEn;
        logic [WDT_TIMER_W-1:0] wdtTimer;
        logic wdtNmi;
        logic wdtReset;
        logic refreshReq;
        logic periphNarrow;
        logic clkA;
        logic clkB;
        logic [15:0] readData;
    } scwr_state_t;

    scwr_state_t st;
    scwr_state_t next_st;
    logic wdtExpire;
    logic [WDT_TIMER_W-1:0] wdtLimit;
    logic [DIV_W-1:0] divMask;
    logic writeAux;
    logic writeSys;
    logic writeWdt;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Terminal count of the watchdog: the lowest set count bit picks the exponent.
    function automatic logic [WDT_TIMER_W-1:0] wdt_limit(input logic [7:0] cnt);
        logic [WDT_TIMER_W-1:0] lim;
        lim = '0;
        for (int k = 7; k >= 0; k--) begin
            if (cnt[k]) begin
                if (k == 0) begin
                    lim = WDT_TIMER_W'((28'h0000001 << WDT_EXP_BIT0) - 28'h0000001);
                end else begin
                    lim = WDT_TIMER_W'((28'h0000001 << (WDT_EXP_OFFSET + k)) - 28'h0000001);
                end
            end
        end
        return lim;
    endfunction

    // Divider mask: all ones in the low F bits while power-save is on, else none.
    always_comb begin
        if (st.sysCfg[SYS_POWER_SAVE_BIT]) begin
            divMask = DIV_W'((8'h01 << st.sysCfg[SYS_DIV_MSB:SYS_DIV_LSB]) - 8'h01);
        end else begin
            divMask = '0;
        end
    end

    assign writeAux = regWrite && (regOffset == OFF_AUX_CFG);
    assign writeSys = regWrite && (regOffset == OFF_SYSTEM_CFG);
    assign writeWdt = regWrite && (regOffset == OFF_WATCHDOG);
    assign wdtLimit = wdt_limit(st.wdtCtl[WDT_COUNT_MSB:WDT_COUNT_LSB]);
    // An all-zero count field has no valid period, so it never expires.
    assign wdtExpire = st.wdtCtl[WDT_ON_BIT] && st.intClkEn && !writeWdt &&
                       (st.wdtCtl[WDT_COUNT_MSB:WDT_COUNT_LSB] != 8'h00) &&
                       (st.wdtTimer == wdtLimit);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Register writes are applied first, then hardware events, so an event
    // landing in the same cycle as a software clear is kept, except a watchdog expiry, which a same-cycle watchdog write blocks.
    always_comb begin
        next_st = st;
        next_st.wdtNmi = 1'b0;
        next_st.wdtReset = 1'b0;
        next_st.refreshReq = 1'b0;

        // Software writes.
        if (writeAux) begin
            next_st.auxCfg = regWriteData & AUX_WRITE_MASK;
        end
        if (writeSys) begin
            next_st.sysCfg = regWriteData & SYS_WRITE_MASK;
        end
        if (writeWdt) begin
            next_st.wdtCtl = regWriteData & WDT_WRITE_MASK;
            next_st.wdtTimer = '0;
        end
        if (regWrite && regOffset == OFF_REFRESH_ENABLE) begin
            next_st.refreshOn = regWriteData[REFRESH_ON_BIT];
        end
        if (regWrite && regOffset == OFF_REFRESH_INTERVAL) begin
            next_st.refreshInterval = regWriteData[REFRESH_W-1:0];
        end
        if (regWrite && regOffset == OFF_REFRESH_BASE) begin
            next_st.refreshBase = regWriteData[15:REFRESH_BASE_LSB];
        end

        // A hardware interrupt drops power-save even against a same-cycle write.
        if (hwInterrupt) begin
            next_st.sysCfg[SYS_POWER_SAVE_BIT] = 1'b0;
        end

        // Clock divider produces the internal clock enable.
        next_st.divCount = st.divCount + DIV_W'(1);
        next_st.intClkEn = ((st.divCount & divMask) == divMask);
        next_st.periphNarrow = st.auxCfg[AUX_MID_NARROW_BIT] && peripheralIsMemory;

        // Clock outputs: fast toggles each cycle, slow on each internal enable.
        if (st.sysCfg[SYS_CLKA_LOW_BIT]) begin
            next_st.clkA = 1'b0;
        end else if (st.sysCfg[SYS_CLKA_FREQ_BIT] || st.intClkEn) begin
            next_st.clkA = ~st.clkA;
        end
        if (st.sysCfg[SYS_CLKB_LOW_BIT]) begin
            next_st.clkB = 1'b0;
        end else if (st.sysCfg[SYS_CLKB_FREQ_BIT] || st.intClkEn) begin
            next_st.clkB = ~st.clkB;
        end

        // Watchdog timer.
        if (!st.wdtCtl[WDT_ON_BIT]) begin
            next_st.wdtTimer = '0;
        end else if (wdtExpire) begin
            next_st.wdtTimer = '0;
            next_st.wdtCtl[WDT_TIMEOUT_BIT] = 1'b1;
            if (st.wdtCtl[WDT_RESET_SEL_BIT] || st.wdtCtl[WDT_NMI_BIT]) begin
                next_st.wdtReset = 1'b1;
            end else begin
                next_st.wdtNmi = 1'b1;
                next_st.wdtCtl[WDT_NMI_BIT] = 1'b1;
            end
        end else if (st.intClkEn && !writeWdt) begin
            next_st.wdtTimer = st.wdtTimer + WDT_TIMER_W'(1);
        end

        // Refresh counter; the row address survives a disable.
        if (!st.refreshOn) begin
            next_st.refreshCount = '0;
        end else if (st.intClkEn) begin
            if (st.refreshCount == st.refreshInterval) begin
                next_st.refreshCount = '0;
                next_st.refreshReq = 1'b1;
                next_st.refreshRow = st.refreshRow + REFRESH_ROW_W'(1);
            end else begin
                next_st.refreshCount = st.refreshCount + REFRESH_W'(1);
            end
        end

        // Read data is captured one cycle after the read strobe.
        if (regRead) begin
            case (regOffset)
                OFF_AUX_CFG: next_st.readData = st.auxCfg;
                OFF_SYSTEM_CFG: next_st.readData = st.sysCfg;
                OFF_WATCHDOG: next_st.readData = st.wdtCtl;
                OFF_REFRESH_ENABLE: next_st.readData = {st.refreshOn, 6'h00, st.refreshCount};
                OFF_REFRESH_INTERVAL: next_st.readData = {7'h00, st.refreshInterval};
                OFF_REFRESH_BASE: next_st.readData = {st.refreshBase, 9'h000};
                default: next_st.readData = ZERO_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // The refresh interval has no defined reset value; zero is chosen so
    // simulation never sees an unknown.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.auxCfg <= AUX_RESET;
            st.sysCfg <= SYS_RESET;
            st.wdtCtl <= WDT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------------
    assign regReadData = st.readData;
    assign port1_rx_flow_select = st.auxCfg[AUX_PORT1_RX_BIT];
    assign port0_rx_flow_select = st.auxCfg[AUX_PORT0_RX_BIT];
    assign port1_tx_flow_select = st.auxCfg[AUX_PORT1_TX_BIT];
    assign port0_tx_flow_select = st.auxCfg[AUX_PORT0_TX_BIT];
    assign low_region_narrow = st.auxCfg[AUX_LOW_NARROW_BIT];
    assign mid_region_narrow = st.auxCfg[AUX_MID_NARROW_BIT];
    assign periphRegionNarrow = st.periphNarrow;
    assign io_space_narrow = st.auxCfg[AUX_IO_NARROW_BIT];
    assign power_save_on = st.sysCfg[SYS_POWER_SAVE_BIT];
    assign internalClockEnable = st.intClkEn;
    assign mid_select_whole_range = st.sysCfg[SYS_MID_WHOLE_BIT];
    assign strobe_mode_select = st.sysCfg[SYS_STROBE_MODE_BIT];
    assign demodulator_on = st.sysCfg[SYS_DEMOD_BIT];
    assign clockOutA = st.clkA;
    assign clockOutB = st.clkB;
    assign watchdogNmi = st.wdtNmi;
    assign watchdogReset = st.wdtReset;
    assign middleSelect3IsRefresh = st.refreshOn;
    assign refreshRequest = st.refreshReq;
    assign refreshAddress = {st.refreshBase, st.refreshRow};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_refresh_hit;
        st.refreshOn && st.intClkEn && (st.refreshCount == st.refreshInterval);
    endsequence

    sequence s_refresh_issue;
        refreshRequest && (st.refreshCount == '0);
    endsequence

    sequence s_nmi_cause;
        wdtExpire && !st.wdtCtl[WDT_RESET_SEL_BIT] && !st.wdtCtl[WDT_NMI_BIT];
    endsequence

    a_power_save_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        hwInterrupt |=> !power_save_on)
        else $error("power save survived a hardware interrupt");

    a_divider_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !power_save_on |=> internalClockEnable)
        else $error("internal clock enable missing without power save");

    // A pulse left over from the previous divider setting is not judged, so a change of factor cannot trip it.
    a_divider_gap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (power_save_on && $stable(st.sysCfg) && st.sysCfg[SYS_DIV_MSB:SYS_DIV_LSB] != 3'h0
         && !writeSys && !hwInterrupt && internalClockEnable) |=> !internalClockEnable)
        else $error("divided clock enable came twice in a row");

    a_clock_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        st.sysCfg[SYS_CLKA_LOW_BIT] |=> !clockOutA)
        else $error("clock output A not held low");

    a_clock_fast: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st.sysCfg[SYS_CLKB_FREQ_BIT] && !st.sysCfg[SYS_CLKB_LOW_BIT]) |=> clockOutB != $past(clockOutB))
        else $error("clock output B did not follow the fast clock");

    a_wdt_nmi_path: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_nmi_cause |=> watchdogNmi && !watchdogReset && st.wdtCtl[WDT_NMI_BIT])
        else $error("watchdog NMI path wrong");

    a_wdt_forced_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wdtExpire && st.wdtCtl[WDT_NMI_BIT]) |=> watchdogReset && !watchdogNmi)
        else $error("flagged NMI did not force a reset");

    a_wdt_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wdtExpire |=> st.wdtCtl[WDT_TIMEOUT_BIT])
        else $error("timeout flag not set");

    a_wdt_off_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !st.wdtCtl[WDT_ON_BIT] |=> !watchdogNmi && !watchdogReset)
        else $error("disabled watchdog fired");

    a_refresh_cleared: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !st.refreshOn |=> (st.refreshCount == '0) && !refreshRequest)
        else $error("refresh counter kept running while disabled");

    a_refresh_request: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_refresh_hit |=> s_refresh_issue)
        else $error("refresh request missing at interval");

    a_enable_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regRead && regOffset == OFF_REFRESH_ENABLE) |=> regReadData[14:9] == 6'h00
        && regReadData[8:0] == $past(st.refreshCount))
        else $error("refresh enable readback wrong");

    a_aux_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
        writeAux |=> port1_rx_flow_select == $past(regWriteData[AUX_PORT1_RX_BIT]))
        else $error("port 1 receive flow select not taken");

    a_low_narrow: assert property (@(posedge sys_clk) disable iff (!rst_b)
        writeAux |=> low_region_narrow == $past(regWriteData[AUX_LOW_NARROW_BIT]))
        else $error("low region width select not taken");

    a_periph_narrow: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rst_b |=> periphRegionNarrow == $past(mid_region_narrow && peripheralIsMemory))
        else $error("peripheral region width wrong");

    a_io_narrow: assert property (@(posedge sys_clk) disable iff (!rst_b)
        writeAux |=> io_space_narrow == $past(regWriteData[AUX_IO_NARROW_BIT]))
        else $error("io space width select not taken");

    a_mid_whole: assert property (@(posedge sys_clk) disable iff (!rst_b)
        writeSys |=> mid_select_whole_range == $past(regWriteData[SYS_MID_WHOLE_BIT]))
        else $error("middle select range bit not taken");

    a_strobe_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        writeSys |=> strobe_mode_select == $past(regWriteData[SYS_STROBE_MODE_BIT]))
        else $error("strobe mode bit not taken");

    a_demod_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
        writeSys |=> demodulator_on == $past(regWriteData[SYS_DEMOD_BIT]))
        else $error("demodulator enable not taken");

    a_wdt_reset_path: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wdtExpire && st.wdtCtl[WDT_RESET_SEL_BIT]) |=> watchdogReset && !watchdogNmi)
        else $error("reset select did not give a reset");

    a_wdt_period: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (wdtExpire && st.wdtCtl[WDT_COUNT_LSB]) |-> st.wdtTimer == (WDT_TIMER_W'(1) << WDT_EXP_BIT0) - WDT_TIMER_W'(1))
        else $error("shortest watchdog period wrong");

    a_interval_upper: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regRead && regOffset == OFF_REFRESH_INTERVAL) |=> regReadData[15:REFRESH_W] == 7'h00)
        else $error("refresh interval upper bits not zero");

    a_refresh_base: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (regWrite && regOffset == OFF_REFRESH_BASE) |=>
        refreshAddress[REFRESH_ROW_W +: REFRESH_BASE_W] == $past(regWriteData[15:REFRESH_BASE_LSB]))
        else $error("refresh base not on the upper address bits");

endmodule

//--- test_scwr_regs.sv
`timescale 1ns/100ps
module test_scwr_regs;
    import scwr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regOffset = 8'h00;
    logic [15:0] regWriteData = 16'h0000;
    logic [15:0] regReadData;
    logic hwInterrupt = 1'b0;
    logic peripheralIsMemory = 1'b0;
    logic p1Rx, p1Tx, p0Rx, p0Tx, lowN, midN, perN, ioN, psOn, clkEn, midWhole, strobeSel, demodOn;
    logic clockOutA, clockOutB, watchdogNmi, watchdogReset, ms3Refresh, refreshRequest;
    logic [19:0] refreshAddress;
    int n_errors = 0;
    int tests_run = 0;

    scwr_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
        .regOffset(regOffset), .regWriteData(regWriteData), .regReadData(regReadData),
        .hwInterrupt(hwInterrupt), .peripheralIsMemory(peripheralIsMemory),
        .port1_rx_flow_select(p1Rx), .port1_tx_flow_select(p1Tx), .port0_rx_flow_select(p0Rx),
        .port0_tx_flow_select(p0Tx), .low_region_narrow(lowN), .mid_region_narrow(midN),
        .periphRegionNarrow(perN), .io_space_narrow(ioN), .power_save_on(psOn),
        .internalClockEnable(clkEn), .mid_select_whole_range(midWhole), .strobe_mode_select(strobeSel),
        .demodulator_on(demodOn), .clockOutA(clockOutA), .clockOutB(clockOutB), .watchdogNmi(watchdogNmi),
        .watchdogReset(watchdogReset), .middleSelect3IsRefresh(ms3Refresh), .refreshRequest(refreshRequest),
        .refreshAddress(refreshAddress));

    // Free-running 125 MHz clock.
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Strobes are raised just after an edge and dropped after the taking edge.
    task automatic wr(input logic [7:0] o, input logic [15:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regOffset <= o;
        regWriteData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] o, input logic [15:0] exp, input string msg);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regOffset <= o;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({4'h0, regReadData}, {4'h0, exp}, msg);
    endtask

    // Counts cycles in which a watched output is high, or toggles for the clock outputs.
    // One edge passes first, so a setting written just before has settled when counting starts.
    task automatic cnt(input int which, input int n, output int c);
        logic prevA;
        logic prevB;
        c = 0;
        @(posedge sys_clk);
        #1;
        prevA = clockOutA;
        prevB = clockOutB;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            case (which)
                0: c += int'(clkEn === 1'b1);
                1: c += int'(refreshRequest === 1'b1);
                2: c += int'(watchdogNmi === 1'b1 || watchdogReset === 1'b1);
                3: c += int'(clockOutA !== prevA);
                default: c += int'(clockOutB !== prevB);
            endcase
            prevA = clockOutA;
            prevB = clockOutB;
        end
    endtask

    // Waits a bounded time for a watchdog pulse; a missing pulse ends the run.
    task automatic wait_dog(input bit wantReset, output int t);
        t = 0;
        while ((wantReset ? watchdogReset : watchdogNmi) !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            t++;
            if (t > 1100) begin
                n_errors++;
                $display("MISMATCH %0t watchdog pulse missing", $time);
                stop_test();
            end
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        rchk(OFF_REFRESH_BASE, 16'h0000, "base reset");
        rchk(OFF_REFRESH_ENABLE, 16'h0000, "enable reset");
        rchk(OFF_WATCHDOG, 16'hC080, "watchdog reset");
        rchk(OFF_SYSTEM_CFG, 16'h0000, "syscfg reset");
        rchk(OFF_AUX_CFG, 16'h0000, "aux reset");
        rchk(8'h50, 16'h0000, "unmapped read");
        $display("test_reset done");
    endtask

    task automatic test_aux();
        @(posedge sys_clk);
        peripheralIsMemory <= 1'b1;
        wr(OFF_AUX_CFG, 16'hFFFF);
        rchk(OFF_AUX_CFG, 16'h007F, "aux readback");
        chk({p1Rx, p0Rx}, 2'b11, "rx flow select");
        chk({p1Tx, p0Tx}, 2'b11, "tx flow select");
        chk({lowN, midN, perN, ioN}, 4'hF, "narrow selects");
        @(posedge sys_clk);
        peripheralIsMemory <= 1'b0;
        wr(OFF_AUX_CFG, 16'h0028);
        rchk(OFF_AUX_CFG, 16'h0028, "aux second");
        chk({p1Rx, p1Tx, p0Rx, p0Tx}, 4'b0101, "mixed flow");
        chk({lowN, midN, perN, ioN}, 4'h0, "wide accesses");
        wr(OFF_AUX_CFG, 16'h0002);
        rchk(OFF_AUX_CFG, 16'h0002, "aux mid only");
        chk({midN, perN}, 2'b10, "periph in io space");
        $display("test_aux done");
    endtask

    task automatic test_system_configuration();
        int c;
        wr(OFF_SYSTEM_CFG, 16'h70FF);
        rchk(OFF_SYSTEM_CFG, 16'h7007, "reserved read zero");
        chk({midWhole, strobeSel, demodOn, psOn}, 4'b1110, "mode bits");
        cnt(0, 8, c);
        chk(c, 8, "divider idle");
        wr(OFF_SYSTEM_CFG, 16'h0A00);
        cnt(3, 8, c);
        chk(c, 8, "clock a fast");
        cnt(4, 8, c);
        chk(c, 8, "clock b fast");
        wr(OFF_SYSTEM_CFG, 16'h0F00);
        cnt(3, 8, c);
        chk({c[3:0], clockOutA, clockOutB, strobeSel, demodOn}, 8'h00, "clocks held low");
        $display("test_system_configuration done");
    endtask

    task automatic test_divider();
        int c;
        for (int f = 0; f < 8; f++) begin
            wr(OFF_SYSTEM_CFG, {8'h80, 5'h00, 3'(f)});
            cnt(0, 256, c);
            cnt(0, 256, c);
            chk(c, 256 >> f, "divided enables");
            if (f == 1) begin
                cnt(3, 16, c);
                chk(c, 8, "clock a divided");
            end
        end
        @(posedge sys_clk);
        hwInterrupt <= 1'b1;
        @(posedge sys_clk);
        hwInterrupt <= 1'b0;
        rchk(OFF_SYSTEM_CFG, 16'h0007, "interrupt clears power save");
        cnt(0, 8, c);
        chk({psOn, 4'(c)}, 5'h08, "full rate again");
        $display("test_divider done");
    endtask

    task automatic test_watchdog();
        int t;
        int c;
        wr(OFF_WATCHDOG, 16'h8001);
        wait_dog(1'b0, t);
        chk(t >= 1018 && t <= 1030, 1'b1, "period two to the ten");
        rchk(OFF_WATCHDOG, 16'hB001, "both flags set");
        wait_dog(1'b1, t);
        chk(t >= 1010 && t <= 1030, 1'b1, "nmi flag forces reset");
        wr(OFF_WATCHDOG, 16'hC001);
        rchk(OFF_WATCHDOG, 16'hC001, "software clears flags");
        wait_dog(1'b1, t);
        chk(watchdogNmi, 1'b0, "reset select no nmi");
        rchk(OFF_WATCHDOG, 16'hE001, "timeout flag only");
        wr(OFF_WATCHDOG, 16'h0001);
        cnt(2, 1200, c);
        chk(c, 0, "disabled watchdog silent");
        $display("test_watchdog done");
    endtask

    task automatic test_refresh();
        int c;
        logic [19:0] a;
        wr(OFF_REFRESH_INTERVAL, 16'hFFFF);
        rchk(OFF_REFRESH_INTERVAL, 16'h01FF, "interval upper zero");
        wr(OFF_REFRESH_BASE, 16'hFFFF);
        rchk(OFF_REFRESH_BASE, 16'hFE00, "base lower zero");
        wr(OFF_REFRESH_INTERVAL, 16'h0003);
        wr(OFF_REFRESH_ENABLE, 16'hFFFF);
        cnt(1, 40, c);
        chk(c, 10, "request every four");
        chk({ms3Refresh, refreshAddress[19:13]}, 8'hFF, "strobe and base");
        rchk(OFF_REFRESH_BASE, 16'hFE00, "base kept");
        wr(OFF_REFRESH_ENABLE, 16'h0000);
        a = refreshAddress;
        rchk(OFF_REFRESH_ENABLE, 16'h0000, "counter cleared");
        cnt(1, 40, c);
        chk(c, 0, "no requests disabled");
        chk({ms3Refresh, refreshAddress}, {1'b0, a}, "address kept");
        wr(OFF_REFRESH_ENABLE, 16'h8000);
        wr(OFF_REFRESH_INTERVAL, 16'h01FF);
        rchk(OFF_REFRESH_ENABLE, 16'h8003, "live counter");
        $display("test_refresh done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        test_reset();
        test_aux();
        test_system_configuration();
        test_divider();
        test_watchdog();
        test_refresh();
        stop_test();
    end
endmodule
